// ===== rtl/fspp_map.svh
/*
 Constants for the flash self-programming protection block.
 Assumes inclusion once per compile unit; guarded against repeats.
*/
`ifndef FSPP_MAP_SVH
`define FSPP_MAP_SVH
`define FSPP_LOCK_RESET 2'h3
`define FSPP_GEN_RESET 2'h3
`define FSPP_FUSE_RESET 1'h1
`define FSPP_RESET_VEC_APP 16'h0000
`define FSPP_PAGE_LSB 7
`define FSPP_PTR_EXT_LSB 16
`define FSPP_LOCK_UPPER 1
`define FSPP_LOCK_LOWER 0
`endif

// ===== rtl/fspp_pkg.sv
/*
 Types shared by the flash self-programming protection block.
 Assumes a SystemVerilog compile including fspp_map.svh where needed.
*/
package fspp_pkg;
	typedef struct packed {
		logic [7:0] ext;
		logic [7:0] high;
		logic [7:0] low;
	} fspp_ptr_t;
	typedef struct packed {
		logic [1:0] app_lock;
		logic [1:0] loader_lock;
	} fspp_locks_t;
	typedef enum logic [1:0] {
		FSPP_IDLE,
		FSPP_BUSY
	} fspp_state_t;
	typedef struct packed {
		fspp_locks_t locks;
		logic [23:0] op_addr;
		fspp_state_t st;
		logic wr_en;
		logic rd_ok;
		logic hi_byte;
		logic irq_block;
		logic [15:0] reset_vec;
		logic started;
		logic loader_fuse;
	} fspp_regs_t;
endpackage : fspp_pkg

// ===== rtl/fspp_core.sv
/*
 Protection decision for self-programming stores and program-memory loads.
 Assumes the core presents one request per cycle and holds operations to
 one cycle pulses; flash sequencing itself lies outside.
*/
`include "fspp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module fspp_core #(
	parameter logic HAS_EXT = 1'b1,
	parameter logic [15:0] LOADER_START = 16'hF000
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire fspp_pkg::fspp_ptr_t ptr_i,
	input wire logic store_program_memory_op_i,
	input wire logic load_program_memory_op_i,
	input wire logic exec_in_loader_i,
	input wire logic vectors_in_loader_i,
	input wire logic [1:0] general_lock_i,
	input wire logic lock_set_i,
	input wire fspp_pkg::fspp_locks_t lock_data_i,
	input wire logic chip_erase_i,
	input wire logic ext_fuse_wr_i,
	input wire logic loader_reset_fuse_i,
	input wire logic op_done_i,
	output logic store_grant_o,
	output logic load_grant_o,
	output logic byte_select_bit_o,
	output logic [23:0] op_addr_o,
	output logic [15:0] page_o,
	output logic [6:0] word_in_page_o,
	output logic irq_block_o,
	output logic [15:0] reset_vec_o,
	output logic busy_o
);
	import fspp_pkg::*;

	fspp_regs_t r;
	fspp_regs_t next_r;
	logic [23:0] ptr_full;
	logic [22:0] word_addr;
	logic tgt_loader;
	logic app_wr_block;
	logic app_rd_block;
	logic ldr_wr_block;
	logic ldr_rd_block;
	logic gen_wr_block;
	logic gen_rd_block;
	logic wr_ok;
	logic rd_ok;

	always_comb begin
		ptr_full = {(HAS_EXT ? ptr_i.ext : 8'h00), ptr_i.high, ptr_i.low};
		word_addr = ptr_full[23:1];
		tgt_loader = (word_addr[15:0] >= LOADER_START) ||
			(word_addr[22:16] != 7'h00);
		app_wr_block = !r.locks.app_lock[`FSPP_LOCK_LOWER];
		app_rd_block = !r.locks.app_lock[`FSPP_LOCK_UPPER];
		ldr_wr_block = !r.locks.loader_lock[`FSPP_LOCK_LOWER];
		ldr_rd_block = !r.locks.loader_lock[`FSPP_LOCK_UPPER];
		gen_wr_block = (general_lock_i != `FSPP_GEN_RESET);
		gen_rd_block = (general_lock_i == 2'h0);
		wr_ok = exec_in_loader_i && !gen_wr_block &&
			!(tgt_loader ? ldr_wr_block : app_wr_block);
		rd_ok = !gen_rd_block &&
			!(exec_in_loader_i && !tgt_loader && app_rd_block) &&
			!(!exec_in_loader_i && tgt_loader && ldr_rd_block);
		// Grants are one-cycle pulses, cleared unless set again below
		next_r = r;
		next_r.wr_en = 1'b0;
		next_r.rd_ok = 1'b0;
		if (chip_erase_i) begin
			next_r.locks = {`FSPP_LOCK_RESET, `FSPP_LOCK_RESET};
		end else if (lock_set_i && exec_in_loader_i) begin
			next_r.locks = r.locks & lock_data_i;
		end
		if (ext_fuse_wr_i) begin
			next_r.loader_fuse = loader_reset_fuse_i;
		end
		// Fuse caught on the first clock after reset release
		if (!r.started) begin
			next_r.started = 1'b1;
			next_r.loader_fuse = loader_reset_fuse_i;
		end
		next_r.reset_vec = next_r.loader_fuse ? `FSPP_RESET_VEC_APP :
			LOADER_START;
		case (r.st)
			FSPP_IDLE: begin
				if (store_program_memory_op_i && wr_ok) begin
					next_r.op_addr = ptr_full;
					next_r.wr_en = 1'b1;
					next_r.st = FSPP_BUSY;
				end
			end
			FSPP_BUSY: begin
				if (op_done_i) begin
					next_r.st = FSPP_IDLE;
				end
			end
			default: next_r.st = FSPP_IDLE;
		endcase
		// Loads skip the idle test: they never touch the latched address
		if (load_program_memory_op_i && rd_ok) begin
			next_r.rd_ok = 1'b1;
			next_r.hi_byte = ptr_full[0];
		end
		// Registered locks: the hold-off lags a lock change by one cycle
		next_r.irq_block =
			(!exec_in_loader_i && vectors_in_loader_i && app_rd_block) ||
			(exec_in_loader_i && !vectors_in_loader_i && ldr_rd_block);
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r <= '0;
			r.locks <= {`FSPP_LOCK_RESET, `FSPP_LOCK_RESET};
			r.loader_fuse <= `FSPP_FUSE_RESET;
			r.reset_vec <= `FSPP_RESET_VEC_APP;
			r.st <= FSPP_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign store_grant_o = r.wr_en;
	assign load_grant_o = r.rd_ok;
	assign byte_select_bit_o = r.hi_byte;
	assign op_addr_o = r.op_addr;
	assign page_o = r.op_addr[23:8];
	assign word_in_page_o = r.op_addr[`FSPP_PAGE_LSB:1];
	assign irq_block_o = r.irq_block;
	assign reset_vec_o = r.reset_vec;
	assign busy_o = (r.st == FSPP_BUSY);

	gen_lock_block_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		store_program_memory_op_i && general_lock_i != 2'h3 |=> !store_grant_o)
		else $error("store granted under general lock");
	read_lock_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		load_program_memory_op_i && general_lock_i == 2'h0 |=> !load_grant_o)
		else $error("load granted under read lock");
	app_store_block_a: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		!r.locks.app_lock[0] && !tgt_loader && store_program_memory_op_i
		|=> !store_grant_o) else $error("app store not blocked");
	ldr_store_block_a: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		!r.locks.loader_lock[0] && tgt_loader && store_program_memory_op_i
		|=> !store_grant_o) else $error("loader store not blocked");
	app_read_deny_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!r.locks.app_lock[1] && exec_in_loader_i && !tgt_loader &&
		load_program_memory_op_i |=> !load_grant_o)
		else $error("app read not denied");
	ldr_read_deny_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!r.locks.loader_lock[1] && !exec_in_loader_i && tgt_loader &&
		load_program_memory_op_i |=> !load_grant_o)
		else $error("loader read not denied");
	app_store_inert_a: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		!exec_in_loader_i |=> !store_grant_o)
		else $error("store from application took effect");
	addr_latch_hold_a: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		busy_o && $past(busy_o) |-> $stable(op_addr_o))
		else $error("latched address moved during operation");
	lock_no_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!chip_erase_i |=> (r.locks & ~$past(r.locks)) == 4'h0)
		else $error("lock bit cleared without chip erase");
	byte_sel_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		load_program_memory_op_i && rd_ok |=> byte_select_bit_o ==
		$past(ptr_full[0])) else $error("byte select wrong");
	open_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		r.locks == 4'hF && general_lock_i == 2'h3 && exec_in_loader_i &&
		store_program_memory_op_i && r.st == FSPP_IDLE |=> store_grant_o)
		else $error("store refused with no locks");

	// Refusals are silent, so only a missing grant can be observed
	// Request checks look one edge after the request, where results settle; vec_select_a, page_split_a and busy_on_a hold in the same cycle

	irq_app_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!exec_in_loader_i && vectors_in_loader_i &&
		!r.locks.app_lock[1] |=> irq_block_o)
		else $error("interrupts not held off in application");

	irq_ldr_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		exec_in_loader_i && !vectors_in_loader_i &&
		!r.locks.loader_lock[1] |=> irq_block_o)
		else $error("interrupts not held off in loader");

	irq_open_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		r.locks == 4'hF |=> !irq_block_o)
		else $error("interrupts held off with no locks");

	vec_select_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		reset_vec_o == (r.loader_fuse ? `FSPP_RESET_VEC_APP : LOADER_START))
		else $error("reset vector does not follow fuse");

	fuse_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		r.started && !ext_fuse_wr_i |=>
		r.loader_fuse == $past(r.loader_fuse))
		else $error("fuse changed without programmer");

	ldr_open_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		r.locks.loader_lock == 2'h3 && tgt_loader && exec_in_loader_i &&
		general_lock_i == 2'h3 && store_program_memory_op_i &&
		r.st == FSPP_IDLE |=> store_grant_o)
		else $error("loader store refused with open pair");

	page_split_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		page_o == op_addr_o[23:8] && word_in_page_o == op_addr_o[7:1])
		else $error("page split wrong");

	addr_capture_a: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		store_program_memory_op_i && wr_ok && r.st == FSPP_IDLE |=>
		op_addr_o == {(HAS_EXT ? $past(ptr_i.ext) : 8'h00),
		$past(ptr_i.high), $past(ptr_i.low)})
		else $error("latched address not the pointer");

	load_refuse_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		load_program_memory_op_i && !rd_ok |=> !load_grant_o)
		else $error("refused load granted");

	erase_restore_a: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		chip_erase_i |=> r.locks == 4'hF)
		else $error("chip erase left a lock bit");

	lock_and_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		lock_set_i && exec_in_loader_i && !chip_erase_i |=>
		r.locks == ($past(r.locks) & $past(lock_data_i)))
		else $error("lock pairs not programmed apart");

	grant_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		store_grant_o |=> !store_grant_o)
		else $error("store grant longer than a cycle");

	busy_on_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		store_grant_o |-> busy_o)
		else $error("granted store not busy");

	busy_refuse_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		busy_o |=> !store_grant_o)
		else $error("store granted while busy");

	busy_free_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		busy_o && op_done_i |=> !busy_o)
		else $error("busy not freed by completion");

	load_open_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		load_program_memory_op_i && general_lock_i == 2'h3 &&
		r.locks == 4'hF |=> load_grant_o)
		else $error("load refused with no locks");

	ldr_load_free_a: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		load_program_memory_op_i && general_lock_i != 2'h0 && tgt_loader &&
		r.locks.loader_lock == 2'h3 |=> load_grant_o)
		else $error("loader load refused with open pair");

	app_load_free_a: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		load_program_memory_op_i && general_lock_i != 2'h0 && !tgt_loader &&
		r.locks.app_lock == 2'h3 |=> load_grant_o)
		else $error("app load refused with open pair");

	wr_lock_two_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		store_program_memory_op_i && general_lock_i == 2'h2
		|=> !store_grant_o)
		else $error("store granted under write lock");

	rw_lock_store_a: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		store_program_memory_op_i && general_lock_i == 2'h0
		|=> !store_grant_o)
		else $error("store granted under read/write lock");
endmodule : fspp_core
`default_nettype wire

// ===== verif/fspp_core_model.sv
/*
 Core model: issues store and load pulses and flash completion.
 Assumes only the bench calls its tasks, from negedge-aligned code.
*/
`timescale 1ns/1ps
`default_nettype none
module fspp_core_model (
	input wire logic mclk_i,
	input wire logic store_grant_i,
	input wire logic load_grant_i,
	output var fspp_pkg::fspp_ptr_t ptr_o,
	output logic store_o,
	output logic load_o,
	output logic done_o
);
	import fspp_pkg::*;
	initial begin
		ptr_o = '0;
		store_o = 1'b0;
		load_o = 1'b0;
		done_o = 1'b0;
	end
	// Grant is caught in either of the two cycles after the op
	task automatic issue(input logic st, input logic [23:0] p,
		output logic seen);
		@(negedge mclk_i);
		ptr_o = p;
		store_o = st;
		load_o = !st;
		@(negedge mclk_i);
		store_o = 1'b0;
		load_o = 1'b0;
		seen = st ? store_grant_i : load_grant_i;
		// Pointer reused at once, so a missing latch shows up
		ptr_o = ~p;
		@(negedge mclk_i);
		seen = seen | (st ? store_grant_i : load_grant_i);
	endtask : issue
	task automatic finish_op();
		@(negedge mclk_i);
		done_o = 1'b1;
		@(negedge mclk_i);
		done_o = 1'b0;
	endtask : finish_op
endmodule : fspp_core_model
`default_nettype wire

// ===== verif/tb.sv
/*
 Bench: random core traffic checked against a reference lock decode.
 Assumes fspp_core and fspp_core_model are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fspp_pkg::*;
	localparam logic [15:0] LDR = 16'hE000;
	logic mclk_i, rst_b_i, exe, vec, lset, cer, fwr, fuse, done;
	logic st_op, ld_op, sg, lg, bsel, irq, busy, seen, xs, tl, st, mbusy;
	logic [1:0] gen, ma, mb;
	logic [23:0] addr, maddr, p;
	logic [15:0] page, rv;
	logic [6:0] wip;
	fspp_ptr_t ptr;
	fspp_locks_t ldat;
	int mismatches, total_checks;
	fspp_core #(.HAS_EXT(1'b1), .LOADER_START(LDR)) u_dut (.mclk_i(mclk_i),
		.rst_b_i(rst_b_i), .ptr_i(ptr), .store_program_memory_op_i(st_op),
		.load_program_memory_op_i(ld_op), .exec_in_loader_i(exe),
		.vectors_in_loader_i(vec), .general_lock_i(gen), .lock_set_i(lset),
		.lock_data_i(ldat), .chip_erase_i(cer), .ext_fuse_wr_i(fwr),
		.loader_reset_fuse_i(fuse), .op_done_i(done), .store_grant_o(sg),
		.load_grant_o(lg), .byte_select_bit_o(bsel), .op_addr_o(addr),
		.page_o(page), .word_in_page_o(wip), .irq_block_o(irq),
		.reset_vec_o(rv), .busy_o(busy));
	fspp_core_model u_core (.mclk_i(mclk_i), .store_grant_i(sg),
		.load_grant_i(lg), .ptr_o(ptr), .store_o(st_op), .load_o(ld_op),
		.done_o(done));
	task automatic chk1(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: flag %b not %b", $time, g, e);
		end
	endtask : chk1
	task automatic chk24(input logic [23:0] g, input logic [23:0] e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask : chk24
	task automatic report_and_stop();
		if (mismatches == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task automatic do_reset(input logic f);
		rst_b_i = 1'b0;
		fuse = f;
		repeat (16) @(negedge mclk_i);
		rst_b_i = 1'b1;
		{ma, mb, maddr, mbusy} = {4'hF, 24'h000000, 1'b0};
		repeat (3) @(negedge mclk_i);
		chk24({8'h00, rv}, f ? 24'h000000 : {8'h00, LDR});
		chk1(busy, 1'b0);
	endtask : do_reset
	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	initial begin
		{mismatches, total_checks} = '0;
		{exe, vec, lset, cer, fwr, gen, ldat} = '0;
		void'($urandom(23));
		do_reset(1'b0);
		fuse = 1'b1;
		repeat (3) @(negedge mclk_i);
		chk24({8'h00, rv}, {8'h00, LDR});
		for (int i = 0; i < 400; i++) begin
			{gen, exe, vec, ldat} = 8'($urandom);
			lset = exe && $urandom % 3 == 0;
			cer = $urandom % 6 == 0;
			// Erase outranks a same-cycle lock write
			if (cer) {ma, mb} = 4'hF;
			else if (lset) {ma, mb} = {ma, mb} & ldat;
			@(negedge mclk_i);
			{lset, cer} = 2'b00;
			p = 24'($urandom);
			if ($urandom % 2 == 0) p[23:17] = 7'h00;
			st = 1'($urandom);
			tl = p[16:1] >= LDR || p[23:17] != 7'h00;
			xs = !mbusy && exe && gen == 2'h3 && (tl ? mb[0] : ma[0]);
			if (!st) xs = gen != 2'h0 && (tl == exe || (tl ? mb[1] : ma[1]));
			u_core.issue(st, p, seen);
			if (st) chk1(seen, xs);
			else chk1(seen, xs);
			if (st && xs) {maddr, mbusy} = {p, 1'b1};
			if (!st && xs) chk1(bsel, p[0]);
			chk24(addr, maddr);
			chk24({page, 1'b0, wip}, {maddr[23:8], 1'b0, maddr[7:1]});
			chk1(busy, mbusy);
			chk1(irq, exe ? !mb[1] && !vec : !ma[1] && vec);
			if (mbusy && $urandom % 3 == 0) begin
				u_core.finish_op();
				mbusy = 1'b0;
				chk1(busy, 1'b0);
			end
		end
		fwr = 1'b1;
		@(negedge mclk_i);
		fwr = 1'b0;
		do_reset(1'b1);
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
